// ### design/flag_bank_pkg.sv
// Shared constants and carrier types for the status flag bank.
// Assumes a single 125 MHz system clock and a synchronous active-low reset.
package flag_bank_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_W = 8;
   localparam int CS_LOW_TIME_US = 2000;
   localparam int CS_LOW_TICKS = (CS_LOW_TIME_US * 1000 + TICK_NS - 1) / TICK_NS;
   localparam int REG_FILTER_TIME_US = 100;
   localparam int REG_FILTER_TICKS = (REG_FILTER_TIME_US * 1000 + TICK_NS - 1) / TICK_NS;
   localparam int CNT_W = 16;
   localparam int WD_W = 16;
   localparam int NUM_FLAGS = 22;

   localparam int F_HS3_GND = 0;
   localparam int F_HS2_GND = 1;
   localparam int F_SPI_PARITY = 2;
   localparam int F_CS_TIMEOUT = 3;
   localparam int F_SUP2_UV = 4;
   localparam int F_SUP1_OV = 5;
   localparam int F_HS0_THERMAL = 6;
   localparam int F_WD_FLASH_HALF = 7;
   localparam int F_WAKE_IO13 = 8;
   localparam int F_WAKE_IO02 = 9;
   localparam int F_WAKE_SPI = 10;
   localparam int F_WAKE_FORCED = 11;
   localparam int F_INT_TIMEOUT = 12;
   localparam int F_SLEEP_OFF_PRIOR = 13;
   localparam int F_RST_REQUEST = 14;
   localparam int F_LEAVE_DEBUG = 15;
   localparam int F_INT_REQUEST = 16;
   localparam int F_RST_HIGH = 17;
   localparam int F_DEBUG_RES = 18;
   localparam int F_REG_PREWARN = 19;
   localparam int F_REG_UV = 20;
   localparam int F_REG_OV = 21;

   typedef logic [NUM_FLAGS-1:0] flags_t;

   localparam flags_t FLAGS_RESET = 22'h000000;
   // Synchroniser reset level: select deasserted, so no false select-low follows reset
   localparam logic [12:0] PINS_IDLE = 13'h0001;
   // Flags that also wait for the fault to go away before a read clears them
   localparam flags_t RECOVERY_MASK = 22'h3c0073;

   typedef struct packed {
      logic hs3_gnd_short;
      logic hs2_gnd_short;
      logic second_supply_low;
      logic first_supply_high;
      logic hs0_over_temp;
      logic reset_pin_high;
      logic reg_temp_prewarn;
      logic reg_under_volt;
      logic reg_over_volt;
      logic debug_pin_low;
      logic [1:0] debug_pin_res;
      logic spi_select_bar;
   } pins_t;

   typedef struct packed {
      logic spi_parity_err;
      logic spi_wake_cmd;
      logic forced_wakeup;
      logic int_service_timeout;
      logic sleep_off_enter;
      logic wake_done;
      logic rst_request;
      logic int_request;
      logic [3:0] wake_io;
   } events_t;

   typedef struct packed {
      logic low_power_mode_reg_on;
      logic flash_mode;
      logic debug_mode;
      logic ov_switch_off_en;
      logic [1:0] debug_res_cfg;
   } cfg_t;
endpackage

// ### design/flag_cell.sv
// One status flag: set by an event, cleared by a read, optionally only after recovery.
// Assumes set, cond and clr are all on the same clock.
`timescale 1ns/100ps
module flag_cell #(
   parameter bit RECOVERY = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic set,
   input wire logic cond,
   input wire logic clr,
   output logic flag
);
   logic flag_d;

   // A set in the clearing cycle wins, so no event is lost
   always_comb begin
      flag_d = flag;
      if (clr && !(RECOVERY && cond)) begin
         flag_d = 1'b0;
      end
      if (set) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else begin
         flag <= flag_d;
      end
   end
endmodule // flag_cell

// ### design/status_flag_bank.sv
// Diagnostic and wake-source status flag bank, read out by the SPI logic.
// Assumes analog comparators arrive as asynchronous pin levels and SPI/mode
// logic drives one-cycle event pulses on CLK.
`timescale 1ns/100ps

// Contract
// - Switch 2 and 3 ground-short flags clear after recovery plus read.
// - SPI parity failure sets a flag; a read clears it.
// - Select held low beyond 2.0 ms sets a flag; read clears it.
// - Second supply undervoltage latches; clears after recovery plus read.
// - First supply overvoltage latches; clears after recovery plus read.
// - Switch 0 overtemperature latches; clears after cooling plus read.
// - In flash mode, watchdog past half its period sets a flag.
// - Wake on input 1 or 3 sets a shared flag; read clears.
// - Wake on input 0 or 2 sets a shared flag; read clears.
// - SPI wake in low-power regulator-on mode sets a flag.
// - Forced timer wake-up sets a flag; read clears it.
// - Expired interrupt service interval sets a flag; read clears it.
// - Regulator-off low-power entry before wake is recorded until read.
// - Reset caused by SPI reset request sets a flag.
// - Leaving debug mode on low debug pin sets a flag.
// - Interrupt requested by SPI command sets a flag.
// - Reset pin shorted high sets a flag; read clears it.
// - Debug resistor mismatch latches; clears once matching and read.
// - Regulator thermal pre-warning latches; clears after cooling plus read.
// - Regulator undervoltage beyond 100 us latches; clears after recovery, read.
// - Regulator overvoltage may switch off the second I/O switch.
// - Regulator overvoltage must persist 100 us; clears after recovery, read.
module status_flag_bank #(
   parameter int CS_LOW_LIMIT = flag_bank_pkg::CS_LOW_TICKS,
   parameter int REG_FILTER_LIMIT = flag_bank_pkg::REG_FILTER_TICKS
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire flag_bank_pkg::pins_t PINS,
   input wire flag_bank_pkg::events_t EVENTS,
   input wire flag_bank_pkg::cfg_t CFG,
   input wire logic [flag_bank_pkg::WD_W-1:0] WD_ELAPSED,
   input wire logic [flag_bank_pkg::WD_W-1:0] WD_PERIOD,
   input wire logic READ_DONE,
   input wire flag_bank_pkg::flags_t READ_SEL,
   output flag_bank_pkg::flags_t FLAGS,
   output logic IO2_SWITCH_OFF
);
   import flag_bank_pkg::*;

   localparam logic [CNT_W-1:0] CS_LIM = CNT_W'(CS_LOW_LIMIT);
   localparam logic [CNT_W-1:0] FILT_LIM = CNT_W'(REG_FILTER_LIMIT);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   pins_t pins_meta_q;
   pins_t pins_q;
   logic debug_low_prev_q;
   logic [TICK_W-1:0] tick_cnt_q;
   logic tick_q;
   logic [CNT_W-1:0] cs_cnt_q;
   logic [CNT_W-1:0] uv_cnt_q;
   logic [CNT_W-1:0] ov_cnt_q;
   logic cs_long_q;
   logic uv_long_q;
   logic ov_long_q;
   logic sleep_off_armed_q;
   logic io_off_q;
   flags_t set_vec;
   flags_t cond_vec;
   flags_t clr_vec;
   flags_t flag_vec;
   logic wd_half;
   logic debug_mismatch;

   // Two-flop synchroniser for every pin level
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         pins_meta_q <= pins_t'(PINS_IDLE);
         pins_q <= pins_t'(PINS_IDLE);
      end else begin
         pins_meta_q <= PINS;
         pins_q <= pins_meta_q;
      end
   end

   // The 2-bit resistor code is not gray coded; a change can show one
   // mixed cycle, which may set the mismatch flag until the next read.
   assign debug_mismatch = (pins_q.debug_pin_res != CFG.debug_res_cfg);

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         debug_low_prev_q <= 1'b0;
      end else begin
         debug_low_prev_q <= pins_q.debug_pin_low;
      end
   end

   // Microsecond tick; long timers count ticks to keep counters narrow
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == TICK_LAST) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // Select low time; one tick of slack is accepted against the 2.0 ms figure
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cs_cnt_q <= '0;
         cs_long_q <= 1'b0;
      end else if (pins_q.spi_select_bar) begin
         cs_cnt_q <= '0;
         cs_long_q <= 1'b0;
      end else begin
         if (tick_q && !cs_long_q) begin
            cs_cnt_q <= cs_cnt_q + 1'b1;
         end
         cs_long_q <= (cs_cnt_q > CS_LIM);
      end
   end

   // Regulator undervoltage persistence filter
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         uv_cnt_q <= '0;
         uv_long_q <= 1'b0;
      end else if (!pins_q.reg_under_volt) begin
         uv_cnt_q <= '0;
         uv_long_q <= 1'b0;
      end else begin
         if (tick_q && !uv_long_q) begin
            uv_cnt_q <= uv_cnt_q + 1'b1;
         end
         uv_long_q <= (uv_cnt_q > FILT_LIM);
      end
   end

   // Regulator overvoltage persistence filter
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ov_cnt_q <= '0;
         ov_long_q <= 1'b0;
      end else if (!pins_q.reg_over_volt) begin
         ov_cnt_q <= '0;
         ov_long_q <= 1'b0;
      end else begin
         if (tick_q && !ov_long_q) begin
            ov_cnt_q <= ov_cnt_q + 1'b1;
         end
         ov_long_q <= (ov_cnt_q > FILT_LIM);
      end
   end

   // Remembers regulator-off low power until the next wake-up
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sleep_off_armed_q <= 1'b0;
      end else if (EVENTS.sleep_off_enter) begin
         sleep_off_armed_q <= 1'b1;
      end else if (EVENTS.wake_done) begin
         sleep_off_armed_q <= 1'b0;
      end
   end

   // Elapsed beyond half the period, compared without a divide
   assign wd_half = CFG.flash_mode && ({WD_ELAPSED, 1'b0} > {1'b0, WD_PERIOD});

   always_comb begin
      set_vec = '0;
      cond_vec = '0;
      set_vec[F_HS3_GND] = pins_q.hs3_gnd_short;
      set_vec[F_HS2_GND] = pins_q.hs2_gnd_short;
      set_vec[F_SPI_PARITY] = EVENTS.spi_parity_err;
      set_vec[F_CS_TIMEOUT] = cs_long_q;
      set_vec[F_SUP2_UV] = pins_q.second_supply_low;
      set_vec[F_SUP1_OV] = pins_q.first_supply_high;
      set_vec[F_HS0_THERMAL] = pins_q.hs0_over_temp;
      set_vec[F_WD_FLASH_HALF] = wd_half;
      set_vec[F_WAKE_IO13] = EVENTS.wake_io[1] | EVENTS.wake_io[3];
      set_vec[F_WAKE_IO02] = EVENTS.wake_io[0] | EVENTS.wake_io[2];
      set_vec[F_WAKE_SPI] = EVENTS.spi_wake_cmd & CFG.low_power_mode_reg_on;
      set_vec[F_WAKE_FORCED] = EVENTS.forced_wakeup;
      set_vec[F_INT_TIMEOUT] = EVENTS.int_service_timeout;
      set_vec[F_SLEEP_OFF_PRIOR] = EVENTS.wake_done & sleep_off_armed_q;
      set_vec[F_RST_REQUEST] = EVENTS.rst_request;
      set_vec[F_LEAVE_DEBUG] = CFG.debug_mode & pins_q.debug_pin_low
                               & ~debug_low_prev_q;
      set_vec[F_INT_REQUEST] = EVENTS.int_request;
      set_vec[F_RST_HIGH] = pins_q.reset_pin_high;
      set_vec[F_DEBUG_RES] = debug_mismatch;
      set_vec[F_REG_PREWARN] = pins_q.reg_temp_prewarn;
      set_vec[F_REG_UV] = uv_long_q;
      set_vec[F_REG_OV] = ov_long_q;
      cond_vec[F_HS3_GND] = pins_q.hs3_gnd_short;
      cond_vec[F_HS2_GND] = pins_q.hs2_gnd_short;
      cond_vec[F_SUP2_UV] = pins_q.second_supply_low;
      cond_vec[F_SUP1_OV] = pins_q.first_supply_high;
      cond_vec[F_HS0_THERMAL] = pins_q.hs0_over_temp;
      cond_vec[F_DEBUG_RES] = debug_mismatch;
      cond_vec[F_REG_PREWARN] = pins_q.reg_temp_prewarn;
      // Recovery uses the raw level, not the filtered one
      cond_vec[F_REG_UV] = pins_q.reg_under_volt;
      cond_vec[F_REG_OV] = pins_q.reg_over_volt;
   end

   // Only flags returned by the finished read frame are cleared
   assign clr_vec = READ_DONE ? READ_SEL : '0;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
         flag_cell #(
            .RECOVERY(RECOVERY_MASK[gi])
         ) u_flag (
            .clk(CLK),
            .rst_n(RST_N),
            .set(set_vec[gi]),
            .cond(cond_vec[gi]),
            .clr(clr_vec[gi]),
            .flag(flag_vec[gi])
         );
      end
   endgenerate

   assign FLAGS = flag_vec;

   // Switch stays off while the overvoltage flag stands, when enabled
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         io_off_q <= 1'b0;
      end else begin
         io_off_q <= CFG.ov_switch_off_en & (ov_long_q | flag_vec[F_REG_OV]);
      end
   end

   assign IO2_SWITCH_OFF = io_off_q;
endmodule // status_flag_bank

// ### tb/flag_bank_checker.sv
// Concurrent checks on the status flag bank ports.
// Assumes binding to the bank; pin levels reach a flag three edges later.
`timescale 1ns/100ps
module flag_bank_checker #(
   parameter int CS_LOW_LIMIT = 4,
   parameter int REG_FILTER_LIMIT = 3
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire flag_bank_pkg::pins_t PINS,
   input wire flag_bank_pkg::events_t EVENTS,
   input wire flag_bank_pkg::cfg_t CFG,
   input wire logic [flag_bank_pkg::WD_W-1:0] WD_ELAPSED,
   input wire logic [flag_bank_pkg::WD_W-1:0] WD_PERIOD,
   input wire logic READ_DONE,
   input wire flag_bank_pkg::flags_t READ_SEL,
   input wire flag_bank_pkg::flags_t FLAGS,
   input wire logic IO2_SWITCH_OFF
);
   import flag_bank_pkg::*;
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   a_parity_sets: assert property (EVENTS.spi_parity_err |=> FLAGS[F_SPI_PARITY])
      else $error("parity flag not set");
   a_read_clears: assert property (READ_DONE && READ_SEL[F_SPI_PARITY] &&
      !EVENTS.spi_parity_err |=> !FLAGS[F_SPI_PARITY]) else $error("read did not clear");
   a_wake_odd: assert property (EVENTS.wake_io[1] || EVENTS.wake_io[3]
      |=> FLAGS[F_WAKE_IO13]) else $error("odd wake flag missing");
   a_wake_even: assert property (EVENTS.wake_io[0] || EVENTS.wake_io[2]
      |=> FLAGS[F_WAKE_IO02]) else $error("even wake flag missing");
   a_spi_wake: assert property (EVENTS.spi_wake_cmd && CFG.low_power_mode_reg_on
      |=> FLAGS[F_WAKE_SPI]) else $error("spi wake flag missing");
   a_flash_half: assert property (CFG.flash_mode &&
      ({WD_ELAPSED, 1'b0} > {1'b0, WD_PERIOD}) |=> FLAGS[F_WD_FLASH_HALF])
      else $error("watchdog half flag missing");
   a_short_latch: assert property (PINS.hs3_gnd_short [*3] |=> FLAGS[F_HS3_GND])
      else $error("ground short flag missing");
   a_uv_holds: assert property (PINS.second_supply_low [*3] ##0 FLAGS[F_SUP2_UV]
      |=> FLAGS[F_SUP2_UV]) else $error("undervoltage flag dropped early");
   a_io2_enable: assert property (IO2_SWITCH_OFF |-> $past(CFG.ov_switch_off_en))
      else $error("switch off without enable");
endmodule // flag_bank_checker

// ### tb/host_reader.sv
// Host model: runs one read frame per request, select low during it.
// Assumes go is raised on a falling edge and held for one cycle.
`timescale 1ns/100ps
module host_reader (
   input wire logic clk,
   input wire logic go,
   input wire flag_bank_pkg::flags_t sel,
   output logic sel_bar,
   output logic done,
   output flag_bank_pkg::flags_t rsel
);
   import flag_bank_pkg::*;
   int n = 0;
   initial begin
      sel_bar = 1'b1;
      done = 1'b0;
      rsel = '0;
   end
   // Outside the frame the selection lines show junk, not the last value
   always @(posedge clk) begin
      done <= 1'b0;
      rsel <= ~sel;
      if (go || n != 0) begin
         sel_bar <= 1'b0;
         n <= n + 1;
      end
      if (n == 4) begin
         done <= 1'b1;
         rsel <= sel;
         sel_bar <= 1'b1;
         n <= 0;
      end
   end
endmodule // host_reader

// ### tb/tb.sv
// Bench top: event, pin, timer and read-clear checks of the flag bank.
// Assumes shortened timer limits and a host model issuing read frames.
`timescale 1ns/100ps
module tb;
   import flag_bank_pkg::*;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   pins_t pins = 13'h0001;
   events_t ev = '0;
   cfg_t cfg = '0;
   logic [WD_W-1:0] wd_el = '0;
   logic [WD_W-1:0] wd_per = 16'h000a;
   logic go = 1'b0;
   flags_t sel = '0;
   logic sel_bar;
   logic done;
   flags_t rsel;
   flags_t flags;
   logic io2_off;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int pb[7] = '{12, 11, 10, 9, 8, 6, 7};
   int fp[7] = '{0, 1, 4, 5, 6, 19, 17};
   int eb[9] = '{11, 9, 8, 5, 4, 3, 2, 1, 0};
   int fe[9] = '{2, 11, 12, 14, 16, 8, 9, 8, 9};
   always #4 CLK = ~CLK;
   host_reader i_host (.clk(CLK), .go(go), .sel(sel), .sel_bar(sel_bar),
      .done(done), .rsel(rsel));
   status_flag_bank #(.CS_LOW_LIMIT(4), .REG_FILTER_LIMIT(3)) i_dut (.CLK(CLK),
      .RST_N(RST_N), .PINS({pins[12:1], sel_bar & pins[0]}), .EVENTS(ev), .CFG(cfg),
      .WD_ELAPSED(wd_el), .WD_PERIOD(wd_per), .READ_DONE(done), .READ_SEL(rsel),
      .FLAGS(flags), .IO2_SWITCH_OFF(io2_off));
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge CLK);
   endtask
   // Read one flag; e lands on the frame-end cycle to test set-over-clear
   task automatic rd(int idx, events_t e);
      int k;
      sel = '0;
      sel[idx] = 1'b1;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      for (k = 0; k < 20 && done !== 1'b1; k++) tick(1);
      ev = e;
      tick(1);
      ev = '0;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      int i;
      tick(3);
      RST_N = 1'b1;
      chk("reset", {io2_off, flags}, '0);
      for (i = 0; i < 9; i++) begin
         ev[eb[i]] = 1'b1;
         tick(1);
         ev = '0;
         chk("event", flags[fe[i]], 1'b1);
         rd(fe[i], '0);
         chk("ev clear", flags, '0);
      end
      ev.spi_parity_err = 1'b1;
      tick(1);
      ev = '0;
      rd(2, 12'h800);
      chk("same cycle", flags[2], 1'b1);
      rd(2, '0);
      chk("same cycle", flags[2], 1'b0);
      for (i = 0; i < 2; i++) begin
         cfg.low_power_mode_reg_on = i;
         ev.spi_wake_cmd = 1'b1;
         tick(1);
         ev = '0;
         chk("spi wake", flags[10], i);
         rd(10, '0);
      end
      ev.wake_done = 1'b1;
      tick(1);
      ev.wake_done = 1'b0;
      ev.sleep_off_enter = 1'b1;
      tick(1);
      ev.sleep_off_enter = 1'b0;
      chk("sleep off", flags[13], 1'b0);
      ev.wake_done = 1'b1;
      tick(1);
      ev = '0;
      chk("sleep off", flags[13], 1'b1);
      rd(13, '0);
      cfg.flash_mode = 1'b1;
      wd_el = 16'h0005;
      tick(2);
      chk("wd half", flags[7], 1'b0);
      wd_el = 16'h0006;
      tick(2);
      chk("wd half", flags[7], 1'b1);
      wd_el = '0;
      rd(7, '0);
      cfg.debug_mode = 1'b1;
      pins.debug_pin_low = 1'b1;
      tick(4);
      chk("debug exit", flags[15], 1'b1);
      rd(15, '0);
      cfg.debug_res_cfg = 2'h1;
      tick(4);
      rd(18, '0);
      chk("dbg res", flags, 22'h040000);
      pins.debug_pin_res = 2'h1;
      tick(4);
      rd(18, '0);
      chk("dbg res", flags, '0);
      for (i = 0; i < 7; i++) begin
         pins[pb[i]] = 1'b1;
         tick(4);
         rd(fp[i], '0);
         chk("pin held", flags[fp[i]], 1'b1);
         pins[pb[i]] = 1'b0;
         tick(4);
         rd(fp[i], '0);
         chk("pin clear", flags, '0);
      end
      pins[0] = 1'b0;
      tick(375);
      chk("cs long", flags[3], 1'b0);
      tick(500);
      chk("cs long", flags[3], 1'b1);
      pins[0] = 1'b1;
      rd(3, '0);
      chk("cs long", flags[3], 1'b0);
      cfg.ov_switch_off_en = 1'b1;
      for (i = 0; i < 2; i++) begin
         pins[5 - i] = 1'b1;
         tick(250);
         chk("filter", flags[20 + i], 1'b0);
         tick(500);
         chk("filter", {io2_off, flags[20 + i]}, {i[0], 1'b1});
         rd(20 + i, '0);
         chk("filter", flags[20 + i], 1'b1);
         pins[5 - i] = 1'b0;
         tick(4);
         rd(20 + i, '0);
         tick(1);
         chk("filter", {io2_off, flags}, '0);
      end
      end_of_test();
   end
endmodule // tb

bind status_flag_bank flag_bank_checker #(.CS_LOW_LIMIT(CS_LOW_LIMIT),
   .REG_FILTER_LIMIT(REG_FILTER_LIMIT)) i_chk (.CLK(CLK), .RST_N(RST_N), .PINS(PINS),
   .EVENTS(EVENTS), .CFG(CFG), .WD_ELAPSED(WD_ELAPSED), .WD_PERIOD(WD_PERIOD),
   .READ_DONE(READ_DONE), .READ_SEL(READ_SEL), .FLAGS(FLAGS),
   .IO2_SWITCH_OFF(IO2_SWITCH_OFF));
